// ### feature_regs_pkg.sv
// Package of offsets, field positions and reset values for the feature and power register bank.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package feature_regs_pkg;

  // Register indices as printed; byte address is four times the index, two words each.
  localparam logic [11:0] IDX_FEATURE_ENABLE  = 12'h1a0;
  localparam logic [11:0] IDX_THERMAL_TARGET  = 12'h1a2;
  localparam logic [11:0] IDX_OFFCORE_SELECT  = 12'h1a6;
  localparam logic [11:0] IDX_POWER_COORD     = 12'h1aa;
  localparam logic [11:0] IDX_POWER_LIMIT     = 12'h1ad;

  // Field positions of the feature-enable register.
  localparam int BIT_PERFMON_AVAIL   = 7;
  localparam int BIT_BTS_UNAVAIL     = 11;
  localparam int BIT_PEBS_UNAVAIL    = 12;
  localparam int BIT_DFVS_ENABLE     = 16;
  localparam int BIT_MONITOR_WAIT    = 18;
  localparam int BIT_LIMIT_QUERY     = 22;
  localparam int BIT_TPR_MSG_DISABLE = 23;
  localparam int BIT_NX_DISABLE      = 34;
  localparam int BIT_TURBO_DISABLE   = 38;

  // Writable mask of the feature-enable register.
  localparam logic [63:0] FEATURE_RW_MASK = 64'h0000_0044_00c5_0000;

  // Thermal target field.
  localparam int THERMAL_LSB = 16;
  localparam int THERMAL_MSB = 23;

  // Power coordination fields.
  localparam int BIT_COORD_DISABLE = 0;
  localparam int BIT_EPB_ENABLE    = 1;
  localparam logic [63:0] COORD_RW_MASK = 64'h0000_0000_0000_0003;

  // Power limit fields.
  localparam int BIT_OVERRIDE_EN = 15;
  localparam logic [63:0] LIMIT_RW_MASK = 64'h0000_0000_0000_ffff;

  // Reset values of the writable registers.
  localparam logic [63:0] FEATURE_RESET = 64'h0000_0000_0001_0000;
  localparam logic [63:0] COORD_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] LIMIT_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] OFFCORE_RESET = 64'h0000_0000_0000_0000;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : feature_regs_pkg

// ### masked_reg64.sv
// One 64-bit software register with a writable mask and per-word byte strobes.
`timescale 1ns/1ps
module masked_reg64
  import feature_regs_pkg::*;
#(
  parameter logic [63:0] RW_MASK   = 64'h0,
  parameter logic [63:0] RESET_VAL = 64'h0
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Write port.
  input  wire logic        we_i,
  input  wire logic        hi_i,
  input  wire logic [3:0]  strb_i,
  input  wire logic [31:0] wdata_i,
  // Stored value.
  output logic      [63:0] q_o
);

  logic [63:0] bytemask;  // Bits addressed by this write.
  logic [63:0] wide_data; // Write data placed in the addressed half.

  // Spread the strobes over the addressed word.
  always_comb begin
    bytemask  = 64'h0;
    wide_data = 64'h0;
    for (int i = 0; i < 4; i++) begin
      if (hi_i) begin
        bytemask[32 + 8*i +: 8] = {8{strb_i[i]}};
      end else begin
        bytemask[8*i +: 8] = {8{strb_i[i]}};
      end
    end
    if (hi_i) begin
      wide_data[63:32] = wdata_i;
    end else begin
      wide_data[31:0] = wdata_i;
    end
  end

  // Reserved and read-only bits never take a write, so they stay at reset value.
  // reserved held
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RESET_VAL & RW_MASK;
    end else if (we_i) begin
      q_o <= (q_o & ~(bytemask & RW_MASK)) | (wide_data & bytemask & RW_MASK);
    end
  end

endmodule : masked_reg64

// ### feature_power_regs.sv
// Feature-enable and power register bank behind an AXI4-Lite slave.
`timescale 1ns/1ps
module feature_power_regs
  import feature_regs_pkg::*;
#(
  parameter int          ADDR_W = 16
) (
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Hardware status inputs, pins from other domains.
  input  wire logic              perfmon_avail_i,
  input  wire logic              bts_unavail_i,
  input  wire logic              pebs_unavail_i,
  input  wire logic [7:0]        thermal_target_i,
  input  wire logic              turbo_capable_i,
  input  wire logic              accel_capable_i,
  // Controls to the processor.
  output logic                   dynamic_freq_voltage_scaling_en_o,
  output logic                   monitor_wait_machine_en_o,
  output logic                   query_limit_en_o,
  output logic                   task_priority_update_msg_dis_o,
  output logic                   no_execute_page_dis_o,
  output logic                   turbo_disable_o,
  output logic                   accel_feature_flag_o,
  output logic                   hw_coord_disable_o,
  output logic                   energy_perf_bias_visible_o,
  output logic                   query_leaf6_ecx3_o,
  output logic [14:0]            package_power_limit_o,
  output logic                   power_override_en_o,
  output logic [63:0]            offcore_response_select_o
);

  // The decode reads address bits 13:2 and checks the bits above them are zero.
  if (ADDR_W < 15) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  //----------------------------------------------------------------------------
  // Reset and input synchronisers
  //----------------------------------------------------------------------------

  logic       rst_meta_r;   // First reset stage.
  logic       rst_n_r;      // Released reset used everywhere.
  logic [12:0] sts_meta_r;  // First stage of the status inputs.
  logic [12:0] sts_r;       // Synchronised status inputs.

  // Release reset through two flops so release is clean.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Status pins come from other logic; two flops before any use. The chain has no
  // reset, so it is already filled when reset lifts and the turbo strap is valid.
  always_ff @(posedge mclk_i) begin
    sts_meta_r <= {perfmon_avail_i, accel_capable_i, turbo_capable_i, thermal_target_i,
                   pebs_unavail_i, bts_unavail_i};
    sts_r      <= sts_meta_r;
  end

  logic       turbo_cap_s;  // Synchronised turbo capability strap.
  logic       accel_cap_s;  // Synchronised acceleration capability.
  logic [7:0] thermal_s;    // Synchronised thermal target.

  assign accel_cap_s = sts_r[11];
  assign turbo_cap_s = sts_r[10];
  assign thermal_s   = sts_r[9:2];

  //----------------------------------------------------------------------------
  // AXI4-Lite write channel
  //----------------------------------------------------------------------------

  logic [ADDR_W-1:0] aw_addr_r;  // Latched write address.
  logic              aw_full_r;  // Write address held.
  logic [31:0]       w_data_r;   // Latched write data.
  logic [3:0]        w_strb_r;   // Latched strobes.
  logic              w_full_r;   // Write data held.
  logic              bvalid_r;   // Write response pending.
  logic [1:0]        bresp_r;    // Write response code.
  logic              wr_go;      // Both halves present: perform the write.

  assign s_axi_awready_o = !aw_full_r && !bvalid_r;
  assign s_axi_wready_o  = !w_full_r && !bvalid_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign wr_go           = aw_full_r && w_full_r && !bvalid_r;

  // Capture address and data in either order.
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_addr_r <= '0;
      aw_full_r <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      w_full_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr_r <= s_axi_awaddr_i;
        aw_full_r <= 1'b1;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
        w_full_r <= 1'b1;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Address decode
  //----------------------------------------------------------------------------

  // Decode a byte address into a one-hot select of the register whose low word it addresses.
  function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
    logic [11:0] idx;
    logic [4:0]  sel;
    idx = a[13:2];
    sel = 5'h0;
    if (a[ADDR_W-1:14] == '0) begin
      if (idx == IDX_FEATURE_ENABLE) sel = 5'h01;
      if (idx == IDX_THERMAL_TARGET) sel = 5'h02;
      if (idx == IDX_OFFCORE_SELECT) sel = 5'h04;
      if (idx == IDX_POWER_COORD)    sel = 5'h08;
      if (idx == IDX_POWER_LIMIT)    sel = 5'h10;
    end
    return sel;
  endfunction : decode

  // Each register is one index; upper 32 bits at the following word index.
  // Hence the high half is taken from the index one above.
  function automatic logic [4:0] decode_any(input logic [ADDR_W-1:0] a, output logic hi);
    logic [4:0] lo_sel;
    lo_sel = decode(a);
    hi = 1'b0;
    if (lo_sel == 5'h0) begin
      lo_sel = decode(a - ADDR_W'(4));
      hi = (lo_sel != 5'h0);
    end
    return lo_sel;
  endfunction : decode_any

  logic [4:0] wsel;  // Selected register for writes.
  logic       whi;   // Upper half write.

  always_comb begin
    whi  = 1'b0;
    wsel = decode_any(aw_addr_r, whi);
  end

  // Response: OKAY on a mapped register, SLVERR elsewhere.
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wsel == 5'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------

  logic [63:0] feat_q;     // Writable feature-enable bits.
  logic [63:0] off_q;      // Off-core response select.
  logic [63:0] coord_q;    // Power coordination control.
  logic [63:0] limit_q;    // Power/current limit.
  logic        turbo_dis_r; // Turbo-disable bit.
  logic        strap_done_r; // Power-on turbo value captured.

  masked_reg64 #(.RW_MASK(FEATURE_RW_MASK), .RESET_VAL(FEATURE_RESET)) u_feat (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_r),
    .we_i    (wr_go && wsel[0]),
    .hi_i    (whi),
    .strb_i  (w_strb_r),
    .wdata_i (w_data_r),
    .q_o     (feat_q)
  );

  masked_reg64 #(.RW_MASK(64'hffff_ffff_ffff_ffff), .RESET_VAL(OFFCORE_RESET)) u_off (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_r),
    .we_i    (wr_go && wsel[2]),
    .hi_i    (whi),
    .strb_i  (w_strb_r),
    .wdata_i (w_data_r),
    .q_o     (off_q)
  );

  masked_reg64 #(.RW_MASK(COORD_RW_MASK), .RESET_VAL(COORD_RESET)) u_coord (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_r),
    .we_i    (wr_go && wsel[3]),
    .hi_i    (whi),
    .strb_i  (w_strb_r),
    .wdata_i (w_data_r),
    .q_o     (coord_q)
  );

  masked_reg64 #(.RW_MASK(LIMIT_RW_MASK), .RESET_VAL(LIMIT_RESET)) u_limit (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_r),
    .we_i    (wr_go && wsel[4]),
    .hi_i    (whi),
    .strb_i  (w_strb_r),
    .wdata_i (w_data_r),
    .q_o     (limit_q)
  );

  // The turbo-disable bit loads the capability strap once after release,
  // because an async reset may only load a constant.
  // power-on shows capability
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      turbo_dis_r  <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      turbo_dis_r  <= turbo_cap_s;
      strap_done_r <= 1'b1;
    end else if (wr_go && wsel[0] && whi && w_strb_r[0]) begin
      turbo_dis_r <= w_data_r[BIT_TURBO_DISABLE - 32];
    end
  end

  //----------------------------------------------------------------------------
  // Read views and outputs
  //----------------------------------------------------------------------------

  logic [63:0] feat_view;     // Full feature-enable read value.
  logic [63:0] thermal_view;  // Thermal target read value.

  // Read-only bits are taken from hardware, never from stored writes.
  // read-only from hardware
  always_comb begin
    feat_view = feat_q;
    feat_view[BIT_PERFMON_AVAIL] = sts_r[12];
    feat_view[BIT_BTS_UNAVAIL] = sts_r[0];
    feat_view[BIT_PEBS_UNAVAIL] = sts_r[1];
    feat_view[BIT_TURBO_DISABLE] = turbo_dis_r;
    thermal_view = 64'h0;
    thermal_view[THERMAL_MSB:THERMAL_LSB] = thermal_s;
  end

  // Control outputs follow the stored bits directly, except the acceleration flag, which also needs accel_cap_s.
  // monitor wait enable
  assign monitor_wait_machine_en_o         = feat_q[BIT_MONITOR_WAIT];
  assign dynamic_freq_voltage_scaling_en_o = feat_q[BIT_DFVS_ENABLE];
  assign query_limit_en_o                  = feat_q[BIT_LIMIT_QUERY];
  assign task_priority_update_msg_dis_o    = feat_q[BIT_TPR_MSG_DISABLE];
  assign no_execute_page_dis_o             = feat_q[BIT_NX_DISABLE];
  assign turbo_disable_o                   = turbo_dis_r;
  assign accel_feature_flag_o              = accel_cap_s && !turbo_dis_r;
  assign hw_coord_disable_o                = coord_q[BIT_COORD_DISABLE];
  assign energy_perf_bias_visible_o        = coord_q[BIT_EPB_ENABLE];
  assign query_leaf6_ecx3_o                = coord_q[BIT_EPB_ENABLE];
  assign package_power_limit_o             = limit_q[14:0];
  assign power_override_en_o               = limit_q[BIT_OVERRIDE_EN];
  assign offcore_response_select_o         = off_q;

  //----------------------------------------------------------------------------
  // AXI4-Lite read channel
  //----------------------------------------------------------------------------

  logic [4:0]  rsel;     // Selected register for reads.
  logic        rhi;      // Upper half read.
  logic [63:0] rword;    // Selected 64-bit value.
  logic        rvalid_r; // Read data pending.

  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_rvalid_o  = rvalid_r;

  // Select the register; unmapped reads give zero.
  // reserved reads zero
  always_comb begin
    rhi   = 1'b0;
    rsel  = decode_any(s_axi_araddr_i, rhi);
    rword = 64'h0;
    unique case (rsel)
      5'h01:   rword = feat_view;
      5'h02:   rword = thermal_view;
      5'h04:   rword = off_q;
      5'h08:   rword = coord_q;
      5'h10:   rword = limit_q;
      default: rword = 64'h0;
    endcase
  end

  // Answer one cycle after the address is taken.
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rvalid_r      <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_r) begin
      rvalid_r      <= 1'b1;
      s_axi_rdata_o <= rhi ? rword[63:32] : rword[31:0];
      s_axi_rresp_o <= (rsel == 5'h0) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule : feature_power_regs

// ### feature_power_regs_assertions.sv
// Checker of bus handshakes and field relations for the feature and power register bank.
`timescale 1ns/1ps
module feature_power_regs_assertions
  import feature_regs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset.
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  // Bus handshakes and answers.
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  // Controls to the processor.
  input wire logic              turbo_disable_o,
  input wire logic              accel_feature_flag_o,
  input wire logic              hw_coord_disable_o,
  input wire logic              energy_perf_bias_visible_o,
  input wire logic              query_leaf6_ecx3_o,
  input wire logic [14:0]       package_power_limit_o,
  input wire logic              power_override_en_o
);
  // Low-word byte addresses; each high word sits four bytes above.
  localparam logic [ADDR_W-1:0] A_FEAT  = ADDR_W'({IDX_FEATURE_ENABLE, 2'b00});
  localparam logic [ADDR_W-1:0] A_THERM = ADDR_W'({IDX_THERMAL_TARGET, 2'b00});
  localparam logic [ADDR_W-1:0] A_OFFC  = ADDR_W'({IDX_OFFCORE_SELECT, 2'b00});
  localparam logic [ADDR_W-1:0] A_COORD = ADDR_W'({IDX_POWER_COORD, 2'b00});
  localparam logic [ADDR_W-1:0] A_LIMIT = ADDR_W'({IDX_POWER_LIMIT, 2'b00});

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // Read address accepted at one byte address.
  sequence ar_at(a);
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == a;
  endsequence
  // Address and data of a write accepted together.
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence

  // True for the ten words that the bank decodes.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a inside {A_FEAT, A_FEAT + 4, A_THERM, A_THERM + 4, A_OFFC, A_OFFC + 4,
                     A_COORD, A_COORD + 4, A_LIMIT, A_LIMIT + 4};
  endfunction : mapped

  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  a_bresp_stable: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped while stalled");
  a_rdata_stable: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer dropped while stalled");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_unmapped_read: assert property (s_axi_arvalid_i && s_axi_arready_o &&
    !mapped(s_axi_araddr_i) |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_feat_reserved: assert property (ar_at(A_FEAT + 4) |=>
    (s_axi_rdata_o & ~32'h0000_0044) == 32'h0)
    else $error("reserved feature bits read nonzero");
  a_turbo_flag: assert property (turbo_disable_o |-> !accel_feature_flag_o)
    else $error("acceleration flag set while turbo disabled");
  a_bias_mirror: assert property (query_leaf6_ecx3_o == energy_perf_bias_visible_o)
    else $error("query bit differs from bias enable");
  a_limit_read: assert property (ar_at(A_LIMIT) |=> s_axi_rdata_o ==
    {16'h0, $past(power_override_en_o), $past(package_power_limit_o)})
    else $error("power limit read disagrees with outputs");
  a_coord_read: assert property (ar_at(A_COORD) |=> s_axi_rdata_o ==
    {30'h0, $past(energy_perf_bias_visible_o), $past(hw_coord_disable_o)})
    else $error("coordination read disagrees with outputs");
endmodule : feature_power_regs_assertions

bind feature_power_regs feature_power_regs_assertions #(.ADDR_W(ADDR_W)) chk_i (.*);

// ### tb.sv
// Self-checking bench for the feature and power register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb
  import feature_regs_pkg::*;
;
  // Bench-driven inputs, all valued at time zero.
  logic        mclk_i = 1'b0, rstn_i = 1'b0;
  logic [15:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0]  s_axi_wstrb_i = '0;
  logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic        perfmon_avail_i = 0, bts_unavail_i = 0, pebs_unavail_i = 0;
  logic        turbo_capable_i = 1, accel_capable_i = 1;
  logic [7:0]  thermal_target_i = '0;
  // Design outputs.
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic        dynamic_freq_voltage_scaling_en_o, monitor_wait_machine_en_o, query_limit_en_o;
  logic        task_priority_update_msg_dis_o, no_execute_page_dis_o, turbo_disable_o;
  logic        accel_feature_flag_o, hw_coord_disable_o, energy_perf_bias_visible_o;
  logic        query_leaf6_ecx3_o, power_override_en_o;
  logic [14:0] package_power_limit_o;
  logic [63:0] offcore_response_select_o;
  // Counters, seed, shadow copies and per-register writable masks.
  int          bad_count = 0, n_tests = 0, seed = 2;
  logic [63:0] sh [5];
  logic [11:0] idx_tab [5] = '{IDX_FEATURE_ENABLE, IDX_THERMAL_TARGET, IDX_OFFCORE_SELECT,
                               IDX_POWER_COORD, IDX_POWER_LIMIT};
  logic [63:0] wm_tab [5] = '{FEATURE_RW_MASK, 64'h0, '1, COORD_RW_MASK, LIMIT_RW_MASK};

  feature_power_regs #(.ADDR_W(16)) feature_power_regs_i (.*);

  // A 20 ns clock.
  always #10 mclk_i = ~mclk_i;

  // Expected 64-bit register contents; status bits come from what the bench drives.
  function automatic logic [63:0] exp_reg(input int k);
    if (k == 0) return sh[0] | (64'(perfmon_avail_i) << 7) | (64'(bts_unavail_i) << 11)
                     | (64'(pebs_unavail_i) << 12);
    if (k == 1) return {40'h0, thermal_target_i, 16'h0};
    return sh[k];
  endfunction : exp_reg

  function automatic logic [15:0] addr_of(input int k, input logic hi);
    return 16'({idx_tab[k], 2'b00}) + (hi ? 16'h4 : 16'h0);
  endfunction : addr_of

  // Write with address and data offered together; each released once taken.
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_tk, w_tk, got;
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      aw_tk = s_axi_awvalid_i && s_axi_awready_o;
      w_tk = s_axi_wvalid_i && s_axi_wready_o;
      @(posedge mclk_i);
      if (aw_tk) s_axi_awvalid_i <= 1'b0;
      if (w_tk) s_axi_wvalid_i <= 1'b0;
    end while ((s_axi_awvalid_i && !aw_tk) || (s_axi_wvalid_i && !w_tk));
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      got = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge mclk_i);
    end while (!got);
    s_axi_bready_i <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      got = s_axi_arready_o;
      @(posedge mclk_i);
    end while (!got);
    s_axi_arvalid_i <= 1'b0;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge mclk_i);
      got = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge mclk_i);
    end while (!got);
    s_axi_rready_i <= 1'b0;
  endtask : axi_read

  // Writes one word and folds the writable lanes into the shadow copy.
  task automatic wr_word(input int k, input logic hi, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    int p;
    axi_write(addr_of(k, hi), d, s, r);
    `CHK(r, RESP_OKAY)
    for (int b = 0; b < 4; b++) begin
      p = hi * 32 + b * 8;
      if (s[b]) sh[k][p+:8] = (d[b*8+:8] & wm_tab[k][p+:8]) | (sh[k][p+:8] & ~wm_tab[k][p+:8]);
    end
  endtask : wr_word

  task automatic rd_word(input int k, input logic hi);
    logic [31:0] d;
    logic [1:0] r;
    logic [63:0] e;
    e = exp_reg(k);
    axi_read(addr_of(k, hi), d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d, e[hi*32+:32])
  endtask : rd_word

  task automatic chk_outputs();
    `CHK(dynamic_freq_voltage_scaling_en_o, sh[0][16])
    `CHK(monitor_wait_machine_en_o, sh[0][18])
    `CHK(query_limit_en_o, sh[0][22])
    `CHK(task_priority_update_msg_dis_o, sh[0][23])
    `CHK(no_execute_page_dis_o, sh[0][34])
    `CHK(turbo_disable_o, sh[0][38])
    `CHK(accel_feature_flag_o, accel_capable_i & ~sh[0][38])
    `CHK(hw_coord_disable_o, sh[3][0])
    `CHK(energy_perf_bias_visible_o, sh[3][1])
    `CHK(query_leaf6_ecx3_o, sh[3][1])
    `CHK(package_power_limit_o, sh[4][14:0])
    `CHK(power_override_en_o, sh[4][15])
    `CHK(offcore_response_select_o, sh[2])
  endtask : chk_outputs

  // Two-cycle reset; the turbo capability pin is settled before release.
  task automatic do_reset(input logic tc);
    rstn_i <= 1'b0;
    turbo_capable_i <= tc;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    sh = '{64'h1_0000 | (64'(tc) << 38), 64'h0, 64'h0, 64'h0, 64'h0};
  endtask : do_reset

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------------
  // Main sequence: reset values, random writes, corners, status, unmapped, reset.
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int k;
    perfmon_avail_i = 1'($random(seed));
    bts_unavail_i = 1'($random(seed));
    pebs_unavail_i = 1'($random(seed));
    thermal_target_i = 8'($random(seed));
    do_reset(1'b1);
    for (k = 0; k < 5; k++) begin
      rd_word(k, 1'b0);
      rd_word(k, 1'b1);
    end
    chk_outputs();
    // Random values and strobes; read-only and reserved lanes must not move.
    repeat (40) begin
      k = $unsigned($random(seed)) % 5;
      wr_word(k, 1'($random(seed)), $random(seed), 4'($random(seed)));
      rd_word(k, 1'b0);
      rd_word(k, 1'b1);
      chk_outputs();
    end
    // All ones then all zeros, back to back, toggling turbo disable both ways.
    for (int v = 0; v < 2; v++) begin
      for (k = 0; k < 5; k++) begin
        wr_word(k, 1'b0, v ? 32'h0 : 32'hffff_ffff, 4'hf);
        wr_word(k, 1'b1, v ? 32'h0 : 32'hffff_ffff, 4'hf);
        rd_word(k, 1'b0);
        rd_word(k, 1'b1);
      end
      chk_outputs();
    end
    // Status pins move; the synchronisers need a few cycles.
    perfmon_avail_i <= ~perfmon_avail_i;
    bts_unavail_i <= ~bts_unavail_i;
    pebs_unavail_i <= ~pebs_unavail_i;
    thermal_target_i <= 8'($random(seed));
    accel_capable_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rd_word(0, 1'b0);
    rd_word(1, 1'b0);
    chk_outputs();
    // Unmapped word between thermal and offcore registers.
    axi_write(16'h0690, 32'hffff_ffff, 4'hf, r);
    `CHK(r, RESP_SLVERR)
    axi_read(16'h0690, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h0)
    for (k = 0; k < 5; k++) begin
      rd_word(k, 1'b0);
    end
    // Second reset on a part without turbo.
    do_reset(1'b0);
    rd_word(0, 1'b1);
    chk_outputs();
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of a few hundred cycles.
  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
